// ### hw/relay_scan_pkg.sv
// shared constants, types and register map of the relay scan status controller
package relay_scan_pkg;
	// register byte offsets on the wishbone bus
	localparam logic [7:0] OFS_SCAN_CFG = 8'h00;
	localparam logic [7:0] OFS_SCAN_LIST = 8'h04;
	localparam logic [7:0] OFS_OPER_EVENT = 8'h08;
	localparam logic [7:0] OFS_OPER_ENABLE = 8'h0c;
	localparam logic [7:0] OFS_SUMMARY = 8'h10;
	localparam logic [7:0] OFS_CARD_CMD = 8'h14;
	localparam logic [7:0] OFS_CARD_QUERY = 8'h18;
	localparam logic [7:0] OFS_ERR_QUEUE = 8'h1c;
	// field positions
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PORT_BIT = 2;
	localparam int SCAN_COMPLETE_BIT = 8;
	localparam int SUMMARY_OPER_BIT = 7;
	localparam int CARD_ALL_BIT = 7;
	localparam int CARD_CPON_BIT = 8;
	localparam int CARD_FULL_RST_BIT = 9;
	localparam int CARD_CLS_BIT = 10;
	localparam int BANK_SIZE = 8;
	// reset values
	localparam logic [15:0] OPER_ENABLE_RESET = 16'h0000;
	localparam logic [15:0] SCAN_LIST_RESET = 16'h0000;
	localparam logic [6:0] CARD_SEL_RESET = 7'h01;
	// value ranges
	localparam logic [6:0] CARD_MIN = 7'h01;
	localparam logic [6:0] CARD_MAX = 7'h63;
	localparam int ERR_DEPTH = 30;
	// error numbers and message indices held by the queue
	localparam logic [15:0] ERR_NUM_NONE = 16'h0000;
	localparam logic [15:0] ERR_NUM_BANK1 = 16'hff20;
	localparam logic [15:0] ERR_NUM_RANGE = 16'hff22;
	localparam logic [15:0] ERR_NUM_OVERFLOW = 16'hfea2;
	localparam logic [7:0] MSG_NO_ERROR = 8'h00;
	localparam logic [7:0] MSG_BANK1 = 8'h01;
	localparam logic [7:0] MSG_RANGE = 8'h02;
	localparam logic [7:0] MSG_OVERFLOW = 8'h03;

	typedef enum logic [1:0] {MODE_NONE, MODE_VOLT, MODE_TWO_WIRE, MODE_FOUR_WIRE} scan_mode_e;

	typedef struct packed {
		logic [7:0] msg;
		logic [15:0] num;
	} err_entry_s;

	typedef struct packed {
		logic second_a_tree_switch;
		logic b_tree_switch;
		logic a_tree_switch;
	} tree_s;
endpackage

// ### hw/relay_mux_scan_status_ctrl.sv
// scan mode, tree switch, operation status, card query and error queue control for a relay mux
// What this block does
// - none and volts modes both set the scan list up for voltage measurement.
// - two-wire ohms mode sets the scan list up for two-wire resistance.
// - four-wire mode: closing bank 0 channel n also closes channel n plus eight.
// - four-wire mode rejects a scan list naming channels 08-15 and queues an error.
// - mode query returns the currently selected mode, one of four.
// - analog bus port closes the mode's tree switches while scanning.
// - port none keeps every tree switch open while scanning.
// - enabled operation bit 8 sets summary status bit 7.
// - enable mask accepts 1 to 65535; 256 passes bit 8 to summary.
// - scan complete sets operation status bit 8.
// - reading the operation event value clears bit 8.
// - operation read returns 256 when bit 8 set, else 0; other bits unused.
// - open-card opens all channels of one card or all, keeping modes.
// - full reset opens all cards and restores power-on mode settings.
// - description query accepts card 1-99 and returns a fixed description.
// - type query returns maker, model, serial always 0, revision.
// - each error entry holds a negative number and a message index.
// - each error read removes and returns the oldest entry.
// - empty queue reads return number 0, message no error.
// - clear status discards every queued error.
// - queue holds 30; overflow replaces newest slot with -350, newer errors lost.
`timescale 1ns/1ns
module relay_mux_scan_status_ctrl
	import relay_scan_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary identity value
	parameter logic [7:0] MODEL_CODE = 8'h21, // arbitrary identity value
	parameter logic [7:0] REV_CODE = 8'h01, // arbitrary identity value
	parameter logic [7:0] DESC_CODE = 8'h03, // arbitrary description index
	parameter int NUM_CH = 16
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scanning_i,
	input wire logic scan_done_i,
	input wire logic [NUM_CH-1:0] chan_close_i,
	output logic [NUM_CH-1:0] scan_list_o,
	output logic list_valid_o,
	output logic [NUM_CH-1:0] relay_close_o,
	output tree_s tree_o,
	output logic summary_o,
	output logic open_card_o,
	output logic open_all_o,
	output logic [6:0] open_card_num_o,
	output logic full_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	scan_mode_e mode_reg;
	logic port_reg;
	logic [NUM_CH-1:0] list_reg;
	logic list_valid_reg;
	logic scan_complete_reg;
	logic [15:0] enable_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic open_card_reg;
	logic open_all_reg;
	logic [6:0] open_num_reg;
	logic full_rst_reg;
	logic [NUM_CH-1:0] relay_reg;
	tree_s tree_reg;
	err_entry_s err_mem [ERR_DEPTH];
	logic [4:0] err_rd_reg;
	logic [4:0] err_wr_reg;
	logic [5:0] err_cnt_reg;

	logic req;
	logic wr_en;
	logic rd_en;
	logic [15:0] wlo;
	logic list_bad;
	logic enable_bad;
	logic card_bad;
	logic query_bad;
	logic cls_cmd;
	logic full_rst_cmd;
	logic err_push;
	err_entry_s err_in;
	logic err_pop;
	logic oper_read;

	// wrap a queue pointer at the queue depth
	function automatic logic [4:0] ptr_inc(input logic [4:0] p);
		ptr_inc = (p == 5'(ERR_DEPTH - 1)) ? 5'h00 : p + 5'h01;
	endfunction

	// card numbers outside 1..99 are refused
	function automatic logic card_out(input logic [6:0] n);
		card_out = (n < CARD_MIN) || (n > CARD_MAX);
	endfunction

	// a request is taken once; ack in the following cycle blocks a second take
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_en = req && wb_we_i;
	assign rd_en = req && !wb_we_i;
	assign wlo = wb_dat_i[15:0];
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// command decode of writes and reads with side effects
	always_comb
	begin
		list_bad = 1'b0;
		enable_bad = 1'b0;
		card_bad = 1'b0;
		query_bad = 1'b0;
		cls_cmd = 1'b0;
		full_rst_cmd = 1'b0;
		err_pop = 1'b0;
		oper_read = 1'b0;
		if (wr_en && wb_adr_i == OFS_SCAN_LIST)
			list_bad = (mode_reg == MODE_FOUR_WIRE) && (|wlo[NUM_CH-1:BANK_SIZE]);
		else if (wr_en && wb_adr_i == OFS_OPER_ENABLE)
			enable_bad = (wlo == 16'h0000);
		else if (wr_en && wb_adr_i == OFS_CARD_CMD)
		begin
			card_bad = wb_dat_i[CARD_CPON_BIT] && !wb_dat_i[CARD_ALL_BIT] && card_out(wb_dat_i[6:0]);
			full_rst_cmd = wb_dat_i[CARD_FULL_RST_BIT];
			cls_cmd = wb_dat_i[CARD_CLS_BIT];
		end
		else if (wr_en && wb_adr_i == OFS_CARD_QUERY)
			query_bad = card_out(wb_dat_i[6:0]);
		else if (rd_en && wb_adr_i == OFS_ERR_QUEUE)
			err_pop = 1'b1;
		else if (rd_en && wb_adr_i == OFS_OPER_EVENT)
			oper_read = 1'b1;
	end

	// one error source per access, so pushes never collide
	assign err_push = list_bad || enable_bad || card_bad || query_bad;
	assign err_in = list_bad ? err_entry_s'{MSG_BANK1, ERR_NUM_BANK1} : err_entry_s'{MSG_RANGE, ERR_NUM_RANGE};

	// bus handshake: one wait state, ack stands one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	// read data, captured at the take so a popped entry is returned intact
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= 32'h00000000;
		else if (rd_en)
		begin
			if (wb_adr_i == OFS_SCAN_CFG)
				dat_reg <= {29'h0, port_reg, mode_reg};
			else if (wb_adr_i == OFS_SCAN_LIST)
				dat_reg <= {15'h0, list_valid_reg, list_reg};
			else if (wb_adr_i == OFS_OPER_EVENT)
				dat_reg <= 32'(scan_complete_reg) << SCAN_COMPLETE_BIT;
			else if (wb_adr_i == OFS_OPER_ENABLE)
				dat_reg <= {16'h0, enable_reg};
			else if (wb_adr_i == OFS_SUMMARY)
				dat_reg <= 32'(summary_o) << SUMMARY_OPER_BIT;
			else if (wb_adr_i == OFS_CARD_QUERY)
				dat_reg <= {MAKER_CODE, MODEL_CODE, 8'h00, REV_CODE};
			else if (wb_adr_i == OFS_ERR_QUEUE)
			begin
				if (err_cnt_reg == 6'h00)
					dat_reg <= {MSG_NO_ERROR, 8'h00, ERR_NUM_NONE};
				else
					dat_reg <= {err_mem[err_rd_reg].msg, 8'h00, err_mem[err_rd_reg].num};
			end
			else
				dat_reg <= 32'h00000000;
		end
		else if (wr_en && wb_adr_i == OFS_CARD_QUERY && !query_bad)
			dat_reg <= {16'h0, 1'b0, wb_dat_i[6:0], DESC_CODE};
	end

	// scan configuration; full reset returns it to power-on state
	always_ff @(posedge clk_i)
	begin
		if (rst_i || full_rst_cmd)
		begin
			mode_reg <= MODE_NONE;
			port_reg <= 1'b0;
		end
		else if (wr_en && wb_adr_i == OFS_SCAN_CFG)
		begin
			mode_reg <= scan_mode_e'(wb_dat_i[CFG_MODE_LSB +: 2]);
			port_reg <= wb_dat_i[CFG_PORT_BIT];
		end
	end

	// scan list is checked against the mode in force when it is written, hence mode first
	always_ff @(posedge clk_i)
	begin
		if (rst_i || full_rst_cmd)
		begin
			list_reg <= SCAN_LIST_RESET;
			list_valid_reg <= 1'b0;
		end
		else if (wr_en && wb_adr_i == OFS_SCAN_LIST)
		begin
			if (list_bad)
				list_valid_reg <= 1'b0;
			else
			begin
				list_reg <= wlo[NUM_CH-1:0];
				list_valid_reg <= 1'b1;
			end
		end
	end

	// scan complete flag: a new completion beats a clearing read
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			scan_complete_reg <= 1'b0;
		else if (scan_done_i)
			scan_complete_reg <= 1'b1;
		else if (oper_read || cls_cmd)
			scan_complete_reg <= 1'b0;
	end

	// enable mask; zero is outside the accepted range and is refused
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			enable_reg <= OPER_ENABLE_RESET;
		else if (wr_en && wb_adr_i == OFS_OPER_ENABLE && !enable_bad)
			enable_reg <= wlo;
	end

	// only bit 8 of the event register exists, so only that mask bit matters
	assign summary_o = scan_complete_reg && enable_reg[SCAN_COMPLETE_BIT];

	// card open commands leave mode and port untouched
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			open_card_reg <= 1'b0;
			open_all_reg <= 1'b0;
			open_num_reg <= CARD_SEL_RESET;
			full_rst_reg <= 1'b0;
		end
		else
		begin
			open_card_reg <= full_rst_cmd || (wr_en && wb_adr_i == OFS_CARD_CMD && wb_dat_i[CARD_CPON_BIT]
				&& !card_bad);
			open_all_reg <= full_rst_cmd || (wr_en && wb_adr_i == OFS_CARD_CMD && wb_dat_i[CARD_ALL_BIT]);
			full_rst_reg <= full_rst_cmd;
			if (wr_en && wb_adr_i == OFS_CARD_CMD && !card_bad)
				open_num_reg <= wb_dat_i[6:0];
		end
	end

	// relay drive: four-wire pairs each bank 0 channel with its bank 1 partner
	generate
		for (genvar i = 0; i < NUM_CH; i++)
		begin : g_relay
			always_ff @(posedge clk_i)
			begin
				if (rst_i || full_rst_cmd)
					relay_reg[i] <= 1'b0;
				else if (i >= BANK_SIZE && mode_reg == MODE_FOUR_WIRE)
					relay_reg[i] <= chan_close_i[i % BANK_SIZE];
				else
					relay_reg[i] <= chan_close_i[i];
			end
		end
	endgenerate

	// tree switches follow the mode only while scanning on the analog bus
	always_ff @(posedge clk_i)
	begin
		if (rst_i || full_rst_cmd || !port_reg || !scanning_i)
			tree_reg <= '0;
		else
		begin
			tree_reg.a_tree_switch <= 1'b1;
			tree_reg.b_tree_switch <= (mode_reg == MODE_TWO_WIRE) || (mode_reg == MODE_FOUR_WIRE);
			tree_reg.second_a_tree_switch <= (mode_reg == MODE_FOUR_WIRE);
		end
	end

	// error queue pointers; overflow rewrites the newest slot and drops the new error
	always_ff @(posedge clk_i)
	begin
		if (rst_i || cls_cmd)
		begin
			err_rd_reg <= 5'h00;
			err_wr_reg <= 5'h00;
			err_cnt_reg <= 6'h00;
		end
		else if (err_push && err_cnt_reg != 6'(ERR_DEPTH))
		begin
			err_wr_reg <= ptr_inc(err_wr_reg);
			err_cnt_reg <= err_cnt_reg + 6'h01;
		end
		else if (err_pop && err_cnt_reg != 6'h00)
		begin
			err_rd_reg <= ptr_inc(err_rd_reg);
			err_cnt_reg <= err_cnt_reg - 6'h01;
		end
	end

	// queue storage
	always_ff @(posedge clk_i)
	begin
		if (err_push && err_cnt_reg != 6'(ERR_DEPTH))
			err_mem[err_wr_reg] <= err_in;
		else if (err_push)
		begin
			err_mem[(err_wr_reg == 5'h00) ? 5'(ERR_DEPTH - 1) : err_wr_reg - 5'h01] <=
				'{msg: MSG_OVERFLOW, num: ERR_NUM_OVERFLOW};
		end
	end

	assign scan_list_o = list_reg;
	assign list_valid_o = list_valid_reg;
	assign relay_close_o = relay_reg;
	assign tree_o = tree_reg;
	assign open_card_o = open_card_reg;
	assign open_all_o = open_all_reg;
	assign open_card_num_o = open_num_reg;
	assign full_reset_o = full_rst_reg;

	// checks
	pair_close_a: assert property (mode_reg == MODE_FOUR_WIRE && chan_close_i[2] && !full_rst_cmd
		|=> relay_close_o[10])
		else $error("bank 1 partner not closed in four-wire mode");
	bank1_reject_a: assert property (list_bad |=> !list_valid_o && err_cnt_reg != 6'h00)
		else $error("bank 1 list accepted in four-wire mode");
	tree_open_a: assert property (!port_reg |=> tree_o == '0)
		else $error("tree switch closed with port none");
	tree_mode_a: assert property (port_reg && scanning_i && mode_reg == MODE_FOUR_WIRE && !full_rst_cmd
		|=> tree_o.second_a_tree_switch && tree_o.b_tree_switch)
		else $error("four-wire tree switches not closed");
	summary_bit_a: assert property (summary_o == (scan_complete_reg && enable_reg[8]))
		else $error("summary bit wrong");
	done_sets_a: assert property (scan_done_i
		|=> scan_complete_reg ##1 (scan_complete_reg || $past(oper_read) || $past(cls_cmd)))
		else $error("scan complete not set");
	read_clears_a: assert property (oper_read && !scan_done_i |=> !scan_complete_reg)
		else $error("event read did not clear");
	oper_value_a: assert property (oper_read
		|=> wb_ack_o && wb_dat_o == ($past(scan_complete_reg) ? 32'h00000100 : 32'h00000000))
		else $error("operation read value wrong");
	empty_read_a: assert property (err_pop && err_cnt_reg == 6'h00 |=> wb_dat_o == 32'h00000000)
		else $error("empty queue read not zero");
	queue_cap_a: assert property (err_cnt_reg <= 6'(ERR_DEPTH))
		else $error("error queue over depth");
	cls_empty_a: assert property (cls_cmd |=> err_cnt_reg == 6'h00)
		else $error("clear status left errors");
	full_reset_a: assert property (full_rst_cmd |=> mode_reg == MODE_NONE && !port_reg && open_all_o)
		else $error("full reset incomplete");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood two cycles");
endmodule // relay_mux_scan_status_ctrl

// ### tb/scan_seq_model.sv
// behavioural scan sequencer driving the block's scan inputs
`timescale 1ns/1ns
module scan_seq_model
#(
	parameter int RUN_CYCLES = 6
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [15:0] pattern_i,
	output logic scanning_o,
	output logic scan_done_o,
	output logic [15:0] chan_close_o
);
	int count_reg;

	// one run holds the channel pattern for a fixed span, then pulses done once
	always_ff @(posedge clk_i)
	begin
		scan_done_o <= 1'b0;
		if (rst_i)
		begin
			count_reg <= 0;
			scanning_o <= 1'b0;
			chan_close_o <= 16'h0000;
		end
		else if (run_i && !scanning_o)
		begin
			count_reg <= RUN_CYCLES;
			scanning_o <= 1'b1;
			chan_close_o <= pattern_i;
		end
		else if (scanning_o)
		begin
			count_reg <= count_reg - 1;
			if (count_reg == 1)
			begin
				scanning_o <= 1'b0;
				scan_done_o <= 1'b1;
				chan_close_o <= 16'h0000; // nothing is wanted closed between runs
			end
		end
	end
endmodule // scan_seq_model

// ### tb/test_relay_mux_scan_status_ctrl.sv
// self-checking bench for the relay scan status controller
`timescale 1ns/1ns
module test_relay_mux_scan_status_ctrl
	import relay_scan_pkg::*;
;
	logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, scanning, scan_done, list_valid, run;
	logic summary, open_card, open_all, full_reset;
	logic [7:0] wb_adr;
	logic [31:0] wb_wdat, wb_rdat, rdv;
	logic [15:0] chan_close, scan_list, relay_close, pattern;
	logic [6:0] card_num;
	tree_s tree;
	int err_total, n_checks, n_open, n_all, n_full, m;

	relay_mux_scan_status_ctrl #(.MAKER_CODE(8'h5a), .MODEL_CODE(8'h21), .REV_CODE(8'h01), .DESC_CODE(8'h03)) u_dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.scanning_i(scanning), .scan_done_i(scan_done), .chan_close_i(chan_close),
		.scan_list_o(scan_list), .list_valid_o(list_valid), .relay_close_o(relay_close), .tree_o(tree),
		.summary_o(summary), .open_card_o(open_card), .open_all_o(open_all),
		.open_card_num_o(card_num), .full_reset_o(full_reset));

	scan_seq_model u_seq (.clk_i(clk), .rst_i(rst), .run_i(run), .pattern_i(pattern),
		.scanning_o(scanning), .scan_done_o(scan_done), .chan_close_o(chan_close));

	always #20 clk = ~clk;

	// pulse counters sampled mid-cycle, away from the launching edge
	always @(negedge clk)
	begin
		n_open += (open_card === 1'b1);
		n_all += (open_all === 1'b1);
		n_full += (full_reset === 1'b1);
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic cycle: request held until the rising edge where ack is sampled high, data taken there
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int i;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		@(posedge clk);
		for (i = 0; i < 20 && wb_ack !== 1'b1; i++)
			@(posedge clk);
		if (wb_ack !== 1'b1)
		begin
			err_total++;
			finish_test();
		end
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] v;
		xfer(1'b1, adr, d, v);
	endtask

	task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] v;
		xfer(1'b0, adr, 32'h0, v);
		chk(what, v, exp);
	endtask

	// one sequencer run; switch drive looked at mid-scan and after it
	task automatic run_scan(input logic [15:0] pat, input logic [2:0] exp_tree, input logic [15:0] exp_relay);
		int i;
		pattern <= pat;
		run <= 1'b1;
		@(posedge clk);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("tree mid scan", {29'h0, tree}, {29'h0, exp_tree});
		chk("relay mid scan", {16'h0, relay_close}, {16'h0, exp_relay});
		for (i = 0; i < 20 && scanning !== 1'b0; i++)
			@(negedge clk);
		if (scanning !== 1'b0)
		begin
			err_total++;
			finish_test();
		end
		@(negedge clk);
		chk("tree idle", {29'h0, tree}, 32'h0);
		@(posedge clk);
	endtask

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		run = 1'b0;
		pattern = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc("mode at reset", OFS_SCAN_CFG, 32'h0);
		chk("card num at reset", {25'h0, card_num}, 32'h1);
		rdc("event at reset", OFS_OPER_EVENT, 32'h0);
		// every mode with and without the bus port; mode and port go before the list
		for (m = 0; m < 8; m++)
		begin
			wr(OFS_SCAN_CFG, {29'h0, m[2:0]});
			rdc("mode readback", OFS_SCAN_CFG, {29'h0, m[2:0]});
			wr(OFS_SCAN_LIST, 32'h3);
			rdc("list", OFS_SCAN_LIST, 32'h0001_0003);
			chk("list out", {15'h0, list_valid, scan_list}, 32'h0001_0003);
			run_scan(16'hc305, {(m[2] && m[1:0] == 2'h3), (m[2] && m[1]), m[2]},
				(m[1:0] == 2'h3) ? 16'h0505 : 16'hc305);
			rdc("scan complete", OFS_OPER_EVENT, 32'h100);
			rdc("clear on read", OFS_OPER_EVENT, 32'h0);
		end
		wr(OFS_SCAN_CFG, 32'h3);
		wr(OFS_SCAN_LIST, 32'h0100);
		chk("list refused", {31'h0, list_valid}, 32'h0);
		rdc("bank one list", OFS_ERR_QUEUE, 32'h0100_ff20);
		rdc("empty queue", OFS_ERR_QUEUE, 32'h0);
		// summary follows the enabled scan complete bit
		wr(OFS_OPER_ENABLE, 32'h100);
		run_scan(16'h0001, 3'h0, 16'h0101);
		chk("summary set", {31'h0, summary}, 32'h1);
		rdc("summary reg", OFS_SUMMARY, 32'h80);
		rdc("event", OFS_OPER_EVENT, 32'h100);
		chk("summary clear", {31'h0, summary}, 32'h0);
		wr(OFS_OPER_ENABLE, 32'h0);
		rdc("enable zero", OFS_ERR_QUEUE, 32'h0200_ff22);
		wr(OFS_OPER_ENABLE, 32'h8000);
		run_scan(16'h0002, 3'h0, 16'h0202);
		chk("summary masked", {31'h0, summary}, 32'h0);
		rdc("event", OFS_OPER_EVENT, 32'h100);
		// card open commands keep modes; full reset restores them
		wr(OFS_SCAN_CFG, 32'h5);
		wr(OFS_CARD_CMD, 32'h180);
		wr(OFS_CARD_CMD, 32'h105);
		wr(OFS_CARD_CMD, 32'h100);
		repeat (2) @(posedge clk);
		chk("card num", {25'h0, card_num}, 32'h5);
		chk("open pulses", n_open, 32'h2);
		chk("open all", n_all, 32'h1);
		rdc("mode kept", OFS_SCAN_CFG, 32'h5);
		rdc("card zero", OFS_ERR_QUEUE, 32'h0200_ff22);
		wr(OFS_CARD_CMD, 32'h200);
		repeat (2) @(posedge clk);
		chk("full reset", n_full, 32'h1);
		chk("reset opens all", n_all, 32'h2);
		rdc("mode restored", OFS_SCAN_CFG, 32'h0);
		rdc("list dropped", OFS_SCAN_LIST, 32'h0);
		// card queries at the range ends
		xfer(1'b1, OFS_CARD_QUERY, 32'h63, rdv);
		chk("description", rdv, 32'h6303);
		rdc("card type", OFS_CARD_QUERY, 32'h5a21_0001);
		xfer(1'b1, OFS_CARD_QUERY, 32'h1, rdv);
		chk("description", rdv, 32'h0103);
		wr(OFS_CARD_QUERY, 32'h64);
		wr(OFS_SCAN_CFG, 32'h3);
		wr(OFS_SCAN_LIST, 32'h8000);
		rdc("oldest first", OFS_ERR_QUEUE, 32'h0200_ff22);
		rdc("next", OFS_ERR_QUEUE, 32'h0100_ff20);
		rdc("then empty", OFS_ERR_QUEUE, 32'h0);
		wr(OFS_OPER_ENABLE, 32'h0);
		wr(OFS_OPER_ENABLE, 32'h0);
		wr(OFS_CARD_CMD, 32'h400);
		rdc("cleared", OFS_ERR_QUEUE, 32'h0);
		// fill past the limit: the thirtieth slot turns into the overflow entry
		for (m = 0; m < 29; m++)
			wr(OFS_OPER_ENABLE, 32'h0);
		wr(OFS_SCAN_LIST, 32'h0100);
		wr(OFS_OPER_ENABLE, 32'h0);
		for (m = 0; m < 29; m++)
			rdc("kept entry", OFS_ERR_QUEUE, 32'h0200_ff22);
		rdc("overflow", OFS_ERR_QUEUE, 32'h0300_fea2);
		rdc("after overflow", OFS_ERR_QUEUE, 32'h0);
		finish_test();
	end
endmodule // test_relay_mux_scan_status_ctrl
